// ===== hw/cfg_check_host.sv
// host controller that runs the configuration signature check sequence
// Overview of operation
// - signature is CRC-8, polynomial x8+x2+x+1
// - fields packed into one 64-bit string
// - bytes fed lowest first, msb first
// - seed FFh, chained, eighth result stored
// - wait 2.1 us before reading result
// - nonvolatile check start, wait 811 us
// - clear enable then set again to rerun
// - store signature, enable, wait, read, clear
// - read config error before nonvolatile check
// - clear enable before reading nonvolatile error
`timescale 1ns/10ps
module cfg_check_host
  import cfg_crc_pkg::*;
#(
  parameter int NVM_WAIT = NVM_WAIT_CYC,  // cycles to wait for nvm check
  parameter int HALF_CYC = SPI_HALF_CYC   // serial half bit in cycles
) (
  input wire logic clock,                 // system clock, 100 MHz
  input wire logic rst_n,                 // synchronous reset, active low
  input wire logic [7:0] awaddr,          // write address
  input wire logic awvalid,               // write address valid
  output logic awready,                   // write address ready
  input wire logic [31:0] wdata,          // write data
  input wire logic [3:0] wstrb,           // write byte strobes
  input wire logic wvalid,                // write data valid
  output logic wready,                    // write data ready
  output logic [1:0] bresp,               // write response
  output logic bvalid,                    // write response valid
  input wire logic bready,                // write response ready
  input wire logic [7:0] araddr,          // read address
  input wire logic arvalid,               // read address valid
  output logic arready,                   // read address ready
  output logic [31:0] rdata,              // read data
  output logic [1:0] rresp,               // read response
  output logic rvalid,                    // read data valid
  input wire logic rready,                // read data ready
  output logic spiClock,                  // serial clock to the device
  output logic spiDataOut,                // serial data to the device
  input wire logic spiDataIn,             // serial data from the device
  output logic spiSelectLow,              // device select, active low
  output logic irq                        // level interrupt, active high
);
  if (NVM_WAIT < CFG_WAIT_CYC) $error("NVM_WAIT too small");

  typedef enum logic [10:0] {
    S_IDLE = 11'h001, S_CRC = 11'h002, S_SIG = 11'h004, S_EN = 11'h008,
    S_WCFG = 11'h010, S_RCFG = 11'h020, S_NVM = 11'h040,
    S_WNVM = 11'h080, S_POLL = 11'h100, S_CLR = 11'h200, S_RNVM = 11'h400
  } state_e;

  // ***************************************
  // register file on the AXI4-Lite slave
  // ***************************************
  logic [31:0] dataLo, dataHi, next_dataLo, next_dataHi, next_rdata, wmask;
  logic [7:0] awAddrHeld, next_awAddrHeld;
  logic [31:0] wDataHeld, next_wDataHeld;
  logic [3:0] wStrbHeld, next_wStrbHeld;
  logic [2:0] irqStatus, irqMask, next_irqStatus, next_irqMask, events;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic goPulse, next_goPulse, goNvm, next_goNvm, next_irq, doWrite;
  logic cfgErr, nvmErr, busy;
  logic [7:0] crcSig;

  // aw and w are taken in either order; the write happens once both held
  always_comb begin
    next_awready = awready;
    next_wready = wready;
    next_awAddrHeld = awAddrHeld;
    next_wDataHeld = wDataHeld;
    next_wStrbHeld = wStrbHeld;
    if (awvalid && awready) begin
      next_awAddrHeld = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready) begin
      next_wDataHeld = wdata;
      next_wStrbHeld = wstrb;
      next_wready = 1'b0;
    end
    doWrite = !awready && !wready && !bvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wStrbHeld[i]}};
    end
    next_dataLo = dataLo;
    next_dataHi = dataHi;
    next_irqMask = irqMask;
    next_goPulse = 1'b0;
    next_goNvm = goNvm;
    next_bvalid = bvalid;
    next_bresp = bresp;
    // hardware events win over a same-cycle write-one clear
    next_irqStatus = irqStatus | events;
    if (doWrite) begin
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (awAddrHeld)
        CTRL_OFS: begin
          next_goPulse = wStrbHeld[0] && wDataHeld[CTRL_GO_BIT] && !busy;
          if (wStrbHeld[0] && !busy) begin
            next_goNvm = wDataHeld[CTRL_NVM_BIT];
          end
        end
        DATA_LO_OFS: next_dataLo = (dataLo & ~wmask) | (wDataHeld & wmask);
        DATA_HI_OFS: next_dataHi = (dataHi & ~wmask) | (wDataHeld & wmask);
        STATUS_OFS: next_bresp = RESP_OKAY;
        IRQ_STATUS_OFS: begin
          next_irqStatus = (irqStatus & ~(wDataHeld[2:0] & wmask[2:0]))
            | events;
        end
        IRQ_MASK_OFS: begin
          next_irqMask = (irqMask & ~wmask[2:0])
            | (wDataHeld[2:0] & wmask[2:0]);
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (araddr)
        CTRL_OFS: next_rdata = {30'h0, goNvm, 1'b0};
        DATA_LO_OFS: next_rdata = dataLo;
        DATA_HI_OFS: next_rdata = dataHi;
        STATUS_OFS: next_rdata = {16'h0, crcSig, 5'h0, nvmErr, cfgErr, busy};
        IRQ_STATUS_OFS: next_rdata = {29'h0, irqStatus};
        IRQ_MASK_OFS: next_rdata = {29'h0, irqMask};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    next_irq = |(next_irqStatus & next_irqMask);
  end

  // register the bus and register-file state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
      dataLo <= DATA_RESET;
      dataHi <= DATA_RESET;
      irqStatus <= 3'h0;
      irqMask <= IRQ_MASK_RESET;
      goPulse <= 1'b0;
      goNvm <= 1'b0;
      irq <= 1'b0;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      awAddrHeld <= next_awAddrHeld;
      wDataHeld <= next_wDataHeld;
      wStrbHeld <= next_wStrbHeld;
      dataLo <= next_dataLo;
      dataHi <= next_dataHi;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      goPulse <= next_goPulse;
      goNvm <= next_goNvm;
      irq <= next_irq;
    end
  end

  // ***************************************
  // check sequencer
  // ***************************************
  state_e state, next_state;
  logic crcStart, next_crcStart, crcBusy, crcDone;
  logic [7:0] crcValue;
  logic issued, next_issued, spiGo, next_spiGo, spiWr, next_spiWr;
  logic [6:0] spiAddr, next_spiAddr;
  logic [7:0] spiWdata, next_spiWdata, spiRdata;
  logic spiDone, next_cfgErr, next_nvmErr, runNvm, next_runNvm;
  logic [7:0] next_crcSig;
  logic [31:0] waitCount, next_waitCount;
  logic [2:0] next_events;

  crc8_serial engine (
    .clock(clock), .rst_n(rst_n), .start(crcStart),
    .data({dataHi, dataLo}),
    .busy(crcBusy), .done(crcDone), .crc(crcValue)
  );

  spi_frame_master #(.HALF_CYC(HALF_CYC)) link (
    .clock(clock), .rst_n(rst_n), .go(spiGo), .wr(spiWr),
    .addr(spiAddr), .wdata(spiWdata), .done(spiDone), .rdata(spiRdata),
    .spiClock(spiClock), .spiDataOut(spiDataOut), .spiDataIn(spiDataIn),
    .spiSelectLow(spiSelectLow)
  );

  // one frame per link state, S_POLL repeating its frame until the start bit reads clear; waits count from the end of the frame
  always_comb begin
    next_state = state;
    next_crcStart = 1'b0;
    next_issued = issued;
    next_spiGo = 1'b0;
    next_spiWr = spiWr;
    next_spiAddr = spiAddr;
    next_spiWdata = spiWdata;
    next_cfgErr = cfgErr;
    next_nvmErr = nvmErr;
    next_crcSig = crcSig;
    next_runNvm = runNvm;
    next_waitCount = waitCount + 32'h1;
    next_events = 3'h0;
    unique case (state)
      S_SIG: {next_spiWr, next_spiAddr, next_spiWdata} =
        {1'b1, DEV_SIG_ADDR, crcSig};
      S_EN: {next_spiWr, next_spiAddr, next_spiWdata} =
        {1'b1, DEV_CHECK_CTRL_ADDR, 8'(1 << CFG_EN_BIT)};
      S_NVM: {next_spiWr, next_spiAddr, next_spiWdata} =
        {1'b1, DEV_SELFTEST_ADDR, 8'(1 << NVM_START_BIT)};
      S_CLR: {next_spiWr, next_spiAddr, next_spiWdata} =
        {1'b1, DEV_CHECK_CTRL_ADDR, 8'h00};
      S_POLL: {next_spiWr, next_spiAddr, next_spiWdata} =
        {1'b0, DEV_SELFTEST_ADDR, 8'h00};
      S_RCFG, S_RNVM: {next_spiWr, next_spiAddr, next_spiWdata} =
        {1'b0, DEV_CHECK_STAT_ADDR, 8'h00};
      default: next_spiWr = 1'b0;
    endcase
    if (!(state inside {S_IDLE, S_CRC, S_WCFG, S_WNVM}) && !issued) begin
      next_spiGo = 1'b1;
      next_issued = 1'b1;
    end
    if (spiDone) begin
      next_issued = 1'b0;
      next_waitCount = 32'h0;
    end
    unique case (state)
      S_IDLE: if (goPulse) begin
        next_state = S_CRC;
        next_crcStart = 1'b1;
        next_runNvm = goNvm;
        next_cfgErr = 1'b0;
        next_nvmErr = 1'b0;
      end
      S_CRC: if (crcDone) begin
        next_crcSig = crcValue;
        next_state = S_SIG;
      end
      S_SIG: if (spiDone) next_state = S_EN;
      S_EN: if (spiDone) next_state = S_WCFG;
      S_WCFG: if (waitCount == 32'(CFG_WAIT_CYC - 1)) begin
        next_state = S_RCFG;
      end
      S_RCFG: if (spiDone) begin
        next_cfgErr = spiRdata[CFG_ERR_BIT];
        next_state = runNvm ? S_NVM : S_CLR;
      end
      S_NVM: if (spiDone) next_state = S_WNVM;
      S_WNVM: if (waitCount == 32'(NVM_WAIT - 1)) next_state = S_POLL;
      S_POLL: if (spiDone && !spiRdata[NVM_START_BIT]) begin
        next_state = S_CLR;
      end
      S_CLR: if (spiDone) begin
        next_state = runNvm ? S_RNVM : S_IDLE;
        next_events = runNvm ? 3'h0 : {1'b0, cfgErr, 1'b1};
      end
      S_RNVM: if (spiDone) begin
        next_nvmErr = spiRdata[NVM_ERR_BIT];
        next_state = S_IDLE;
        next_events = {spiRdata[NVM_ERR_BIT], cfgErr, 1'b1};
      end
    endcase
  end

  // register sequencer state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= S_IDLE;
      crcStart <= 1'b0;
      issued <= 1'b0;
      spiGo <= 1'b0;
      spiWr <= 1'b0;
      spiAddr <= 7'h00;
      spiWdata <= 8'h00;
      cfgErr <= 1'b0;
      nvmErr <= 1'b0;
      crcSig <= CRC_SEED;
      runNvm <= 1'b0;
      waitCount <= 32'h0;
      events <= 3'h0;
    end else begin
      state <= next_state;
      crcStart <= next_crcStart;
      issued <= next_issued;
      spiGo <= next_spiGo;
      spiWr <= next_spiWr;
      spiAddr <= next_spiAddr;
      spiWdata <= next_spiWdata;
      cfgErr <= next_cfgErr;
      nvmErr <= next_nvmErr;
      crcSig <= next_crcSig;
      runNvm <= next_runNvm;
      waitCount <= next_waitCount;
      events <= next_events;
    end
  end
  assign busy = (state != S_IDLE);

  // ***************************************
  // checks on the sequence
  // ***************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] gap;
  logic enOnDev, sigFresh;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap <= 32'h0;
      enOnDev <= 1'b0;
      sigFresh <= 1'b0;
    end else begin
      gap <= spiDone ? 32'h0 : gap + 32'h1;
      if (spiDone && state == S_EN) enOnDev <= 1'b1;
      if (spiDone && state == S_CLR) enOnDev <= 1'b0;
      if (spiDone && state == S_SIG) sigFresh <= 1'b1;
      if (spiDone && state == S_EN) sigFresh <= 1'b0;
    end
  end
  property p_string;
    crcStart |=> engine.busy && engine.hold == $past({dataHi, dataLo});
  endproperty
  a_string: assert property (p_string) else $error("string mispacked");
  property p_cfg_wait;
    $rose(state == S_RCFG) |-> gap >= 32'(CFG_WAIT_CYC);
  endproperty
  a_cfg_wait: assert property (p_cfg_wait) else $error("read early");
  property p_nvm_wait;
    $rose(state == S_POLL) |-> gap >= 32'(NVM_WAIT);
  endproperty
  a_nvm_wait: assert property (p_nvm_wait) else $error("poll early");
  property p_rerun;
    spiGo && state == S_EN |-> !enOnDev;
  endproperty
  a_rerun: assert property (p_rerun) else $error("enable not cleared");
  property p_sig_first;
    spiGo && state == S_EN |-> sigFresh && spiWdata == 8'(1 << CFG_EN_BIT);
  endproperty
  a_sig_first: assert property (p_sig_first) else $error("sig missing");
  property p_read_first;
    $rose(state == S_NVM) |-> $past(state) == S_RCFG;
  endproperty
  a_read_first: assert property (p_read_first) else $error("nvm early");
  property p_clear_first;
    $rose(state == S_RNVM) |-> $past(state) == S_CLR && !enOnDev;
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("bad seq");
  c_cfg_pass: cover property (state == S_RCFG && spiDone && !spiRdata[0]);
  c_cfg_fail: cover property (events[IRQ_CFG_BIT]);
  c_nvm_run: cover property (state == S_RNVM && spiDone);
endmodule // cfg_check_host

// ===== common/cfg_crc_pkg.sv
// shared constants for the configuration signature check controller
package cfg_crc_pkg;
  // ***************************************
  // timing
  // ***************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CFG_CRC_TIME_NS = 2100;
  localparam int CFG_WAIT_CYC =
    (CFG_CRC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVM_CRC_TIME_US = 811;
  localparam int NVM_WAIT_CYC = NVM_CRC_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SPI_HALF_CYC = 4;
  // ***************************************
  // signature arithmetic
  // ***************************************
  localparam int STRING_W = 64;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'hff;
  // ***************************************
  // device register map reached over the serial link
  // ***************************************
  localparam logic [6:0] DEV_SIG_ADDR = 7'h01;
  localparam logic [6:0] DEV_CHECK_CTRL_ADDR = 7'h02;
  localparam logic [6:0] DEV_CHECK_STAT_ADDR = 7'h03;
  localparam logic [6:0] DEV_SELFTEST_ADDR = 7'h04;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_ERR_BIT = 0;
  localparam int NVM_ERR_BIT = 1;
  localparam int NVM_START_BIT = 0;
  // ***************************************
  // own register map on the AXI4-Lite slave
  // ***************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATA_LO_OFS = 8'h04;
  localparam logic [7:0] DATA_HI_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_NVM_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CFG_BIT = 1;
  localparam int IRQ_NVM_BIT = 2;
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/crc8_serial.sv
// bit-serial signature engine over the 64-bit protected string
`timescale 1ns/10ps
module crc8_serial
  import cfg_crc_pkg::*;
(
  input wire logic clock,                 // system clock
  input wire logic rst_n,                 // synchronous reset, active low
  input wire logic start,                 // one-cycle start pulse
  input wire logic [STRING_W-1:0] data,   // string, taken at start
  output logic busy,                      // engine running
  output logic done,                      // one-cycle finish pulse
  output logic [7:0] crc                  // running / final signature
);
  logic [STRING_W-1:0] hold, next_hold;
  logic [5:0] count, next_count;
  logic next_busy, next_done;
  logic [7:0] next_crc;
  logic inBit;

  // pick byte count[5:3] from the low end, bit 7 down to 0 inside it
  always_comb begin
    inBit = hold[{count[5:3], ~count[2:0]}];
    next_hold = hold;
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    next_crc = crc;
    if (start && !busy) begin
      next_hold = data;
      next_count = 6'h00;
      next_busy = 1'b1;
      next_crc = CRC_SEED;
    end else if (busy) begin
      // byte results chain straight into the next byte
      next_crc = {crc[6:0], 1'b0}
        ^ ((crc[7] ^ inBit) ? CRC_POLY : 8'h00);
      next_count = count + 6'h01;
      if (count == 6'h3f) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // register the engine state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold <= '0;
      count <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
      crc <= CRC_SEED;
    end else begin
      hold <= next_hold;
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
      crc <= next_crc;
    end
  end

  property p_seed;
    @(posedge clock) disable iff (!rst_n)
    start && !busy |=> crc == 8'hff;
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded");
  property p_zero_vec;
    @(posedge clock) disable iff (!rst_n)
    start && !busy && data == 64'h0 |-> ##65 (done && crc == 8'hdb);
  endproperty
  a_zero_vec: assert property (p_zero_vec) else $error("zero vec bad");
  property p_mixed_vec;
    @(posedge clock) disable iff (!rst_n)
    start && !busy && data == 64'h0a23e00018fe7b80
      |-> ##65 (done && crc == 8'h1b);
  endproperty
  a_mixed_vec: assert property (p_mixed_vec) else $error("order bad");
endmodule // crc8_serial

// ===== hw/spi_frame_master.sv
// 16-bit serial frame master: command byte then data byte, msb first
`timescale 1ns/10ps
module spi_frame_master
  import cfg_crc_pkg::*;
#(
  parameter int HALF_CYC = SPI_HALF_CYC   // clock cycles per serial half bit
) (
  input wire logic clock,                 // system clock
  input wire logic rst_n,                 // synchronous reset, active low
  input wire logic go,                    // one-cycle frame request
  input wire logic wr,                    // frame writes the device
  input wire logic [6:0] addr,            // device register address
  input wire logic [7:0] wdata,           // byte to write
  output logic done,                      // one-cycle end of frame
  output logic [7:0] rdata,               // byte read in the frame
  output logic spiClock,                  // serial clock, idle low
  output logic spiDataOut,                // data to the device
  input wire logic spiDataIn,             // data from the device
  output logic spiSelectLow               // frame select, active low
);
  if (HALF_CYC < 3) $error("HALF_CYC must cover the input synchroniser");

  logic syncA, syncB, active, next_active, next_done, tick;
  logic next_spiClock, next_spiDataOut, next_spiSelectLow;
  logic [15:0] shift, next_shift;
  logic [4:0] bitCount, next_bitCount;
  logic [7:0] next_rdata;
  logic [15:0] divCount, next_divCount;

  // divider enable paces every half bit
  always_comb begin
    tick = active && (divCount == 16'(HALF_CYC - 1));
    next_divCount = (!active || tick) ? 16'h0000 : divCount + 16'h0001;
    next_active = active;
    next_done = 1'b0;
    next_shift = shift;
    next_bitCount = bitCount;
    next_rdata = rdata;
    next_spiClock = spiClock;
    next_spiDataOut = spiDataOut;
    next_spiSelectLow = spiSelectLow;
    if (go && !active) begin
      next_active = 1'b1;
      next_shift = {wr, addr, wdata};
      next_spiDataOut = wr;
      next_spiSelectLow = 1'b0;
      next_bitCount = 5'h00;
    end else if (tick && !spiClock) begin
      next_spiClock = 1'b1;
      next_shift = {shift[14:0], syncB};
    end else if (tick) begin
      next_spiClock = 1'b0;
      if (bitCount == 5'h0f) begin
        next_active = 1'b0;
        next_done = 1'b1;
        next_spiSelectLow = 1'b1;
        next_spiDataOut = 1'b0;
        next_rdata = shift[7:0];
      end else begin
        next_bitCount = bitCount + 5'h01;
        next_spiDataOut = shift[15];
      end
    end
  end

  // register frame state; input passes two flops first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      active <= 1'b0;
      done <= 1'b0;
      shift <= 16'h0000;
      bitCount <= 5'h00;
      rdata <= 8'h00;
      divCount <= 16'h0000;
      spiClock <= 1'b0;
      spiDataOut <= 1'b0;
      spiSelectLow <= 1'b1;
    end else begin
      syncA <= spiDataIn;
      syncB <= syncA;
      active <= next_active;
      done <= next_done;
      shift <= next_shift;
      bitCount <= next_bitCount;
      rdata <= next_rdata;
      divCount <= next_divCount;
      spiClock <= next_spiClock;
      spiDataOut <= next_spiDataOut;
      spiSelectLow <= next_spiSelectLow;
    end
  end
endmodule // spi_frame_master

// ===== testbench/cfg_device_model.sv
// behavioural device: serial registers, signature and nonvolatile checks
`timescale 1ns/10ps
module cfg_device_model
  import cfg_crc_pkg::*;
#(
  parameter int NVM_TIME = 100 // cycles of the nonvolatile check
) (
  input wire logic clock, // system clock
  input wire logic spiClock, // serial clock
  input wire logic spiDataOut, // data from host
  output logic spiDataIn, // data to host
  input wire logic spiSelectLow, // select, active low
  input wire logic [63:0] cfgString // protected contents
);
  logic [15:0] sh;
  logic [7:0] sig, rd;
  localparam logic [6:0] LOCK_ADDR = 7'h05; // write-lock register
  logic en, cfgErr, nvmErr, nvmRun, safe, selD, lock;
  int bits, t;
  // power-on state: lock released
  initial begin
    {sh, sig, rd, en, cfgErr, nvmErr, nvmRun, safe, lock, spiDataIn} = '0;
    selD = 1'b1;
    bits = 0;
    t = 0;
  end
  // signature: low byte first, msb first, one running register
  function automatic logic [7:0] sign(input logic [63:0] s);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 0; i < 64; i++)
      c = {c[6:0], 1'b0}
        ^ ((c[7] ^ s[8*(i/8)+7-i%8]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  // shift host bits in on the rising serial clock
  always @(posedge spiClock) if (!spiSelectLow) begin
    sh <= {sh[14:0], spiDataOut};
    bits <= bits + 1;
  end
  // answer byte goes out after the falling edge; released line toggles
  always @(negedge spiClock) if (!spiSelectLow && bits >= 8 && bits < 16) begin
    if (bits == 8)
      case (sh[6:0])
        DEV_CHECK_STAT_ADDR: rd = {6'h0, nvmErr, cfgErr};
        DEV_SELFTEST_ADDR: rd = {7'h0, nvmRun};
        DEV_CHECK_CTRL_ADDR: rd = {7'h0, en};
        default: rd = sig;
      endcase
    spiDataIn <= rd[15-bits];
  end
  always @(posedge spiSelectLow) spiDataIn <= ~spiDataIn;
  // register writes at frame end, nonvolatile check timer
  always @(posedge clock) begin
    selD <= spiSelectLow;
    if (spiSelectLow) bits <= 0;
    if (spiSelectLow && !selD && sh[15] && bits == 16) begin
      case (sh[14:8])
        DEV_SIG_ADDR: if (!lock) sig <= sh[7:0];
        LOCK_ADDR: lock <= sh[0];
        DEV_CHECK_CTRL_ADDR: begin
          en <= sh[0];
          if (sh[0] && !en)
            cfgErr <= sign(cfgString) != sig;
          if (!sh[0] && en && cfgErr) begin
            nvmErr <= 1'b1;
            safe <= 1'b1;
          end
        end
        DEV_SELFTEST_ADDR: if (sh[0]) begin
          nvmRun <= 1'b1;
          nvmErr <= 1'b1;
          t <= NVM_TIME;
        end
        default: ;
      endcase
    end else if (nvmRun) begin
      t <= t - 1;
      if (t == 0) {nvmRun, nvmErr, cfgErr} <= 3'h0;
    end
  end
endmodule // cfg_device_model

// ===== testbench/cfg_check_host_tb.sv
// testbench for the configuration signature check controller
`timescale 1ns/10ps
module cfg_check_host_tb import cfg_crc_pkg::*; ();
  logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, irq;
  logic arvalid, arready, rvalid, rready;
  logic spiClock, spiDataOut, spiDataIn, spiSelectLow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [63:0] cfgString;
  localparam logic [63:0] V = 64'h0a23e00018fe7b80;
  int fail_count, cmp_count, n;
  cfg_check_host #(.NVM_WAIT(300)) u_cfg_check_host (.*);
  cfg_device_model u_cfg_device_model (.*);
  task automatic check(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic lim(input int m);
    if (++n > m) begin
      fail_count++;
      test_done;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    n = 0;
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(posedge clock);
      lim(50);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    n = 0;
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge clock);
      lim(50);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    {rv, rs} = {rdata, rresp};
  endtask
  // load string, start, poll busy
  task automatic run(input logic [63:0] s, input logic [1:0] c);
    wr(DATA_LO_OFS, s[31:0]);
    wr(DATA_HI_OFS, s[63:32]);
    wr(CTRL_OFS, {30'h0, c});
    for (int k = 0; k < 2000; k++) begin
      rd(STATUS_OFS);
      if (rv[0] === 1'b0) return;
    end
    fail_count++;
    test_done;
  endtask
  // reset value of the low data word and a refused offset
  task automatic t_map;
    rd(DATA_LO_OFS);
    check("data", DATA_RESET, rv);
    rd(8'h40);
    check("rd resp", RESP_SLVERR, rs);
    check("rd data", 32'h0, rv);
    wr(8'h40, 32'h0);
    check("wr resp", RESP_SLVERR, rs);
  endtask
  // matching signature, no nonvolatile check
  task automatic t_match;
    run(V, 2'h1);
    check("sig", 32'h1b, {24'h0, rv[15:8]});
    check("cfg ok", 1'b0, rv[1]);
    check("dev sig", 8'h1b, u_cfg_device_model.sig);
  endtask
  // mismatch, then a passing nonvolatile check clears it
  task automatic t_nvm;
    wr(IRQ_MASK_OFS, 32'h7);
    run(64'h0, 2'h3);
    check("cfg seen", 1'b1, rv[1]);
    check("nvm", 32'h0, {rv[2], u_cfg_device_model.safe});
    check("irq", 1'b1, irq);
    rd(CTRL_OFS);
    check("ctrl", 32'h2, rv);
    wr(IRQ_STATUS_OFS, 32'h7);
    repeat (3) @(posedge clock);
    check("irq clr", 1'b0, irq);
  endtask
  // mismatch, then the enable clear sends the device safe
  task automatic t_safe;
    run(64'h0, 2'h1);
    check("cfg err", 1'b1, rv[1]);
    check("zero sig", 32'hdb, {24'h0, rv[15:8]});
    rd(IRQ_STATUS_OFS);
    check("irq st", 32'h3, rv);
    check("safe", 1'b1, u_cfg_device_model.safe);
    check("nvm flag", 1'b1, u_cfg_device_model.nvmErr);
  endtask
  // free-running clock
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
    {wdata, fail_count, cmp_count} = '0;
    wstrb = 4'hf;
    cfgString = V;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_map;
    t_match;
    t_nvm;
    t_safe;
    test_done;
  end
endmodule // cfg_check_host_tb
